// [src/sync_burst_read_sequencer.sv]
`timescale 1ns/10ps
module sync_burst_read_sequencer (
	input  wire logic                        clock_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        burst_clk_i,
	input  wire logic                        chip_sel_n_i,
	input  wire logic                        out_en_n_i,
	input  wire logic                        address_latch_strobe_n_i,
	input  wire logic [bseq_pkg::ADDR_W-1:0] addr_i,
	input  wire logic                        async_page_select_i,
	input  wire logic [3:0]                  first_access_latency_i,
	input  wire logic                        wait_active_high_i,
	input  wire logic                        wait_early_release_i,
	input  wire logic                        clock_edge_rising_i,
	input  wire logic                        burst_nowrap_i,
	input  wire logic [2:0]                  burst_len_code_i,
	output logic [bseq_pkg::ADDR_W-1:0]      word_addr_o,
	output logic                             data_valid_o,
	output logic                             wait_o,
	output logic                             wait_oe_o,
	output logic                             burst_active_o
);
	burst_step_if sp ();

	bseq_pkg::seq_state_t        st;
	bseq_pkg::seq_state_t        next_st;
	logic [bseq_pkg::ADDR_W-1:0] cur_addr;
	logic [bseq_pkg::ADDR_W-1:0] next_addr;
	logic [3:0]                  cnt;
	logic [3:0]                  next_cnt;
	logic [4:0]                  words;
	logic [4:0]                  next_words;
	logic                        crossed;
	logic                        next_crossed;
	logic [1:0]                  start_ofs;
	logic [1:0]                  next_start_ofs;
	logic                        burst_clk_q;
	logic                        step;
	logic                        seq_on;
	logic                        bus_act;
	logic [3:0]                  lc_eff;
	logic [4:0]                  len;
	logic                        last_word;
	logic                        next_wait;

	// =====================================================
	// burst clock edge selection
	// the burst clock is sampled and its chosen edge becomes an enable
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			burst_clk_q <= bseq_pkg::RST_LOW;
		end else begin
			burst_clk_q <= burst_clk_i;
		end
	end

	// one step per chosen edge of the burst clock
	assign step = clock_edge_rising_i ? (burst_clk_i && !burst_clk_q)
		: (!burst_clk_i && burst_clk_q);

	// =====================================================
	// mode and configuration decode
	assign seq_on  = !chip_sel_n_i && !async_page_select_i;
	assign bus_act = !chip_sel_n_i && !out_en_n_i;
	// reserved short latencies fall back to the shortest usable one
	assign lc_eff  = (first_access_latency_i < bseq_pkg::LAT_MIN) ? bseq_pkg::LAT_MIN
		: first_access_latency_i;
	assign len       = bseq_pkg::burst_words(burst_len_code_i);
	assign last_word = (len != bseq_pkg::WORDS_INF) && (words == len - 5'h01);

	// =====================================================
	// address stepping unit
	assign sp.cur_addr  = cur_addr;
	assign sp.mask      = bseq_pkg::wrap_mask(burst_len_code_i, burst_nowrap_i);
	assign sp.crossed   = crossed;
	assign sp.stall_len = bseq_pkg::row_stall(start_ofs, lc_eff);

	burst_addr_step u_step (
		.st (sp)
	);

	// =====================================================
	// sequence decision for the coming step
	always_comb begin
		next_st        = st;
		next_cnt       = cnt;
		next_addr      = cur_addr;
		next_words     = words;
		next_crossed   = crossed;
		next_start_ofs = start_ofs;
		if (!address_latch_strobe_n_i) begin
			// a new burst starts; latency counts from here
			next_st        = bseq_pkg::ST_LAT;
			next_cnt       = lc_eff;
			next_addr      = addr_i;
			next_words     = bseq_pkg::RST_WORDS;
			next_crossed   = 1'b0;
			next_start_ofs = addr_i[1:0];
		end else begin
			case (st)
				bseq_pkg::ST_LAT: begin
					if (cnt == 4'h1) begin
						next_st = bseq_pkg::ST_DATA;
					end else begin
						next_cnt = cnt - 4'h1;
					end
				end
				bseq_pkg::ST_DATA: begin
					if (last_word || sp.at_top) begin
						next_st = bseq_pkg::ST_DONE;
					end else begin
						next_addr  = sp.next_addr;
						next_words = words + 5'h01;
						if (sp.to_stall) begin
							// only one stall per burst
							next_st      = bseq_pkg::ST_STALL;
							next_cnt     = sp.stall_len;
							next_crossed = 1'b1;
						end
					end
				end
				bseq_pkg::ST_STALL: begin
					if (cnt == 4'h1) begin
						next_st = bseq_pkg::ST_DATA;
					end else begin
						next_cnt = cnt - 4'h1;
					end
				end
				default: begin
					next_st = st;
				end
			endcase
		end
	end

	// wait level wanted after the coming step
	always_comb begin
		case (next_st)
			bseq_pkg::ST_LAT: begin
				// early release frees wait one data cycle ahead
				next_wait = !(wait_early_release_i && next_cnt == 4'h1);
			end
			bseq_pkg::ST_STALL: begin
				next_wait = 1'b1;
			end
			default: begin
				next_wait = 1'b0;
			end
		endcase
	end

	// =====================================================
	// sequencer state
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st <= bseq_pkg::ST_IDLE;
		end else if (!seq_on) begin
			st <= bseq_pkg::ST_IDLE;
		end else if (step) begin
			st <= next_st;
		end
	end

	// burst counters and addresses
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			cur_addr  <= bseq_pkg::RST_ADDR;
			cnt       <= bseq_pkg::RST_CNT;
			words     <= bseq_pkg::RST_WORDS;
			crossed   <= bseq_pkg::RST_LOW;
			start_ofs <= 2'h0;
		end else if (seq_on && step) begin
			cur_addr  <= next_addr;
			cnt       <= next_cnt;
			words     <= next_words;
			crossed   <= next_crossed;
			start_ofs <= next_start_ofs;
		end
	end

	// =====================================================
	// data launch outputs
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			word_addr_o  <= bseq_pkg::RST_ADDR;
			data_valid_o <= bseq_pkg::RST_LOW;
		end else if (!seq_on || !bus_act) begin
			data_valid_o <= bseq_pkg::RST_LOW;
		end else if (step) begin
			word_addr_o  <= next_addr;
			data_valid_o <= (next_st == bseq_pkg::ST_DATA);
		end
	end

	// burst in progress
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			burst_active_o <= bseq_pkg::RST_LOW;
		end else if (!seq_on) begin
			burst_active_o <= bseq_pkg::RST_LOW;
		end else if (step) begin
			burst_active_o <= (next_st != bseq_pkg::ST_IDLE) && (next_st != bseq_pkg::ST_DONE);
		end
	end

	// =====================================================
	// wait pin
	// driven only while selected with output enabled, so writes float it
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wait_oe_o <= bseq_pkg::RST_LOW;
		end else begin
			wait_oe_o <= bus_act;
		end
	end

	// level moves on chosen edges only while active; an idle bus or async mode parks it released
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wait_o <= bseq_pkg::RST_LOW;
		end else if (!bus_act || !seq_on) begin
			wait_o <= !wait_active_high_i;
		end else if (step) begin
			wait_o <= next_wait ? wait_active_high_i : !wait_active_high_i;
		end
	end

	// =====================================================
	// assertions
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	logic wait_on;
	assign wait_on = wait_o == wait_active_high_i;

	// wait pin drive and level
	wait_float_a : assert property (out_en_n_i |=> !wait_oe_o)
		else $error("wait pin driven with output disabled");
	oe_follow_a : assert property (bus_act |=> wait_oe_o)
		else $error("wait pin not driven in an active cycle");
	wait_step_a : assert property ($changed(wait_o) && $past(bus_act) && $past(seq_on)
		|-> $past(step))
		else $error("wait moved off the chosen edge");
	quiet_level_a : assert property (!bus_act || !seq_on
		|=> wait_o == !$past(wait_active_high_i))
		else $error("wait not released outside bursts");
	wait_valid_a : assert property (data_valid_o && !wait_early_release_i
		&& $stable(wait_active_high_i) |-> !wait_on)
		else $error("wait asserted while data valid");
	early_release_a : assert property ($rose(data_valid_o) && $past(st == bseq_pkg::ST_LAT)
		&& wait_early_release_i && $stable(wait_active_high_i) |-> $past(!wait_on))
		else $error("wait not released ahead of first word");
	wait_late_a : assert property ($rose(data_valid_o) && !wait_early_release_i
		&& $past(st != bseq_pkg::ST_DATA) && $stable(wait_active_high_i)
		|-> $past(wait_on))
		else $error("wait released before the first word");

	// burst length and address order
	burst_len_a : assert property (data_valid_o && len != bseq_pkg::WORDS_INF
		|-> words < len)
		else $error("burst ran past its length");
	top_stop_a : assert property (data_valid_o && (&word_addr_o) && step
		|=> !data_valid_o)
		else $error("burst ran past the end of the space");
	wrap_block_a : assert property ($changed(word_addr_o) && data_valid_o
		&& $past(data_valid_o) && sp.mask != 4'h0
		|-> word_addr_o[bseq_pkg::ADDR_W-1:bseq_pkg::ROW_W]
		== $past(word_addr_o[bseq_pkg::ADDR_W-1:bseq_pkg::ROW_W]))
		else $error("wrapped burst left its block");
	linear_step_a : assert property ($changed(word_addr_o) && data_valid_o
		&& $past(data_valid_o) && sp.mask == 4'h0
		|-> word_addr_o == $past(word_addr_o) + 26'h0000001)
		else $error("linear burst skipped a word");
	edge_only_a : assert property ($changed(word_addr_o) |-> $past(step))
		else $error("address moved off the chosen edge");

	// row crossing stall
	stall_once_a : assert property (st == bseq_pkg::ST_STALL
		&& $past(st == bseq_pkg::ST_DATA) |-> $past(!crossed))
		else $error("second row stall in one burst");
	stall_linear_a : assert property (st == bseq_pkg::ST_STALL |-> sp.mask == 4'h0)
		else $error("row stall in a wrapped burst");
	stall_bound_a : assert property (st == bseq_pkg::ST_STALL
		|-> start_ofs != 2'h0 && cnt <= lc_eff - 4'h1)
		else $error("row stall too long or on aligned start");
	stall_wait_a : assert property (st == bseq_pkg::ST_STALL && bus_act && seq_on
		&& $past(step) && $stable(wait_active_high_i) |-> wait_on)
		else $error("stall cycle without wait");

	// read mode and first access latency
	async_off_a : assert property (async_page_select_i |=> !data_valid_o
		&& st == bseq_pkg::ST_IDLE)
		else $error("burst active in page mode");
	lat_first_a : assert property ($rose(data_valid_o) && $past(st == bseq_pkg::ST_LAT)
		|-> $past(cnt) == 4'h1)
		else $error("first word before latency elapsed");

	wrap4_c : cover property (data_valid_o && sp.mask == 4'h3 && last_word);
	stall_c : cover property (st == bseq_pkg::ST_STALL && cnt > 4'h1);
	cont_c  : cover property (data_valid_o && len == bseq_pkg::WORDS_INF && words == 5'h1f);
	early_c : cover property (wait_early_release_i && $rose(data_valid_o));
	fall_c  : cover property (!clock_edge_rising_i && $rose(data_valid_o));
endmodule : sync_burst_read_sequencer

// [src/bseq_pkg.sv]
// Functional notes
// - wait held asserted until output word valid
// - wait pin floats during writes, output disabled
// - early release frees wait one cycle ahead
// - only linear burst ordering exists
// - length code picks 4, 8, 16, continuous
// - wrap mode increments modulo length within block
// - no-wrap mode increments linearly across boundaries
// - continuous never wraps, stops at space end
// - chosen clock edge launches data and wait
// - row-crossing stall once, only on crossing
// - no stall aligned; worst latency minus one
// - wait asserted on every stall cycle
// - async page select disables burst sequencing
// - latency counts edges from latch to data
// - polarity bit picks asserted wait level
// - in active bus cycles of burst mode wait changes only on chosen edges
package bseq_pkg;
	localparam int         ADDR_W   = 26;
	localparam int         ROW_W    = 4;
	// burst length codes
	localparam logic [2:0] BL_4     = 3'h1;
	localparam logic [2:0] BL_8     = 3'h2;
	localparam logic [2:0] BL_16    = 3'h3;
	localparam logic [2:0] BL_CONT  = 3'h7;
	localparam logic [4:0] WORDS_4  = 5'h04;
	localparam logic [4:0] WORDS_8  = 5'h08;
	localparam logic [4:0] WORDS_16 = 5'h10;
	localparam logic [4:0] WORDS_INF = 5'h00;
	// shortest usable latency count
	localparam logic [3:0] LAT_MIN  = 4'h3;
	// reset values
	localparam logic [ADDR_W-1:0] RST_ADDR = 26'h0000000;
	localparam logic       RST_LOW  = 1'b0;
	localparam logic [3:0] RST_CNT  = 4'h0;
	localparam logic [4:0] RST_WORDS = 5'h00;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_LAT   = 5'h02,
		ST_DATA  = 5'h04,
		ST_STALL = 5'h08,
		ST_DONE  = 5'h10
	} seq_state_t;

	// words per burst, zero meaning continuous
	function automatic logic [4:0] burst_words(input logic [2:0] code);
		case (code)
			BL_4:    burst_words = WORDS_4;
			BL_8:    burst_words = WORDS_8;
			BL_16:   burst_words = WORDS_16;
			default: burst_words = WORDS_INF;
		endcase
	endfunction : burst_words

	// low address bits that wrap, zero when linear
	function automatic logic [3:0] wrap_mask(input logic [2:0] code, input logic nowrap);
		logic [4:0] w;
		w = burst_words(code);
		if (nowrap || w == WORDS_INF) begin
			wrap_mask = 4'h0;
		end else begin
			wrap_mask = 4'(w - 5'h01);
		end
	endfunction : wrap_mask

	// stall cycles at the first row crossing
	function automatic logic [3:0] row_stall(input logic [1:0] ofs, input logic [3:0] lc);
		if (ofs == 2'h3) begin
			row_stall = lc - 4'h1;
		end else begin
			row_stall = {2'h0, ofs};
		end
	endfunction : row_stall
endpackage : bseq_pkg

// [src/burst_step_if.sv]
`timescale 1ns/10ps
// address stepping request and answer
interface burst_step_if;
	logic [bseq_pkg::ADDR_W-1:0] cur_addr;
	logic [3:0]                  mask;
	logic                        crossed;
	logic [3:0]                  stall_len;
	logic [bseq_pkg::ADDR_W-1:0] next_addr;
	logic                        to_stall;
	logic                        at_top;
	modport seq (output cur_addr, mask, crossed, stall_len,
		input next_addr, to_stall, at_top);
	modport gen (input cur_addr, mask, crossed, stall_len,
		output next_addr, to_stall, at_top);
endinterface : burst_step_if

// [src/burst_addr_step.sv]
`timescale 1ns/10ps
module burst_addr_step (
	burst_step_if.gen st
);
	logic [bseq_pkg::ROW_W-1:0] low_inc;

	// =====================================================
	// next word address
	// only linear order is produced, wrapped or not
	always_comb begin
		low_inc = st.cur_addr[bseq_pkg::ROW_W-1:0] + 4'h1;
		if (st.mask == 4'h0) begin
			st.next_addr = st.cur_addr + 26'h0000001;
		end else begin
			st.next_addr = {st.cur_addr[bseq_pkg::ADDR_W-1:bseq_pkg::ROW_W],
				(st.cur_addr[bseq_pkg::ROW_W-1:0] & ~st.mask) | (low_inc & st.mask)};
		end
	end

	// =====================================================
	// first row crossing in linear bursts may stall
	assign st.to_stall = (st.mask == 4'h0) && !st.crossed && (low_inc == 4'h0)
		&& (st.stall_len != 4'h0);
	// end of the burstable space
	assign st.at_top = &st.cur_addr;
endmodule : burst_addr_step

// [tb/flash_host_model.sv]
`timescale 1ns/10ps
// ==========================================================
// host side: burst clock, bus strobes and word capture
module flash_host_model (
	input  wire logic                        clock_i,
	input  wire logic                        rising_i,
	input  wire logic [bseq_pkg::ADDR_W-1:0] word_addr_i,
	input  wire logic                        data_valid_i,
	input  wire logic                        wait_i,
	input  wire logic                        active_i,
	output logic                             burst_clk_o,
	output logic                             chip_sel_n_o,
	output logic                             out_en_n_o,
	output logic                             address_latch_strobe_n_o,
	output logic [bseq_pkg::ADDR_W-1:0]      addr_o
);
	logic [bseq_pkg::ADDR_W-1:0] words[$];
	logic                        waits[$];
	logic                        valids[$];
	logic                        actives[$];

	// quiet bus at time zero
	initial begin
		burst_clk_o = 1'b0;
		chip_sel_n_o = 1'b1;
		out_en_n_o = 1'b1;
		address_latch_strobe_n_o = 1'b1;
		addr_o = '0;
	end

	// set bus strobes, then let the block settle
	task automatic bus(input logic cs_n, input logic oe_n);
		@(posedge clock_i);
		#1;
		chip_sel_n_o = cs_n;
		out_en_n_o = oe_n;
		address_latch_strobe_n_o = 1'b1;
		repeat (3) @(posedge clock_i);
		#1;
	endtask : bus

	// one read burst; step 0 loads the address, clock rests outside the frame
	task automatic burst(input logic [bseq_pkg::ADDR_W-1:0] a, input int steps);
		words.delete();
		waits.delete();
		valids.delete();
		actives.delete();
		@(posedge clock_i);
		#1;
		burst_clk_o = !rising_i;
		chip_sel_n_o = 1'b0;
		out_en_n_o = 1'b0;
		address_latch_strobe_n_o = 1'b0;
		addr_o = a;
		repeat (2) @(posedge clock_i);
		for (int i = 0; i <= steps; i++) begin
			#1;
			burst_clk_o = rising_i;
			repeat (2) @(posedge clock_i);
			#1;
			address_latch_strobe_n_o = 1'b1;
			addr_o = ~a;
			waits.push_back(wait_i);
			valids.push_back(data_valid_i);
			actives.push_back(active_i);
			// stall and latency steps carry no word
			if (data_valid_i === 1'b1) begin
				words.push_back(word_addr_i);
			end
			burst_clk_o = !rising_i;
			repeat (2) @(posedge clock_i);
		end
		bus(1'b1, 1'b1);
	endtask : burst
endmodule : flash_host_model

// [tb/sync_burst_read_sequencer_bench.sv]
`timescale 1ns/10ps
// ==========================================================
// bench for the burst read sequencer
module sync_burst_read_sequencer_bench;
	localparam int AW = bseq_pkg::ADDR_W;
	logic          clock_i = 1'b0;
	logic          rst_n_i = 1'b0;
	logic          page = 1'b0;
	logic [3:0]    lat = 4'h3;
	logic          pol = 1'b1;
	logic          early = 1'b0;
	logic          rising = 1'b1;
	logic          nowrap = 1'b0;
	logic [2:0]    code = 3'h1;
	logic          bclk;
	logic          cs_n;
	logic          oe_n;
	logic          stb_n;
	logic [AW-1:0] addr;
	logic [AW-1:0] waddr;
	logic          valid;
	logic          wait_s;
	logic          wait_oe;
	logic          active;
	int            n_mismatch = 0;
	int            cmp_count = 0;
	int            cycles = 0;

	always #5 clock_i = ~clock_i;

	sync_burst_read_sequencer sync_burst_read_sequencer_inst (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .burst_clk_i(bclk), .chip_sel_n_i(cs_n), .out_en_n_i(oe_n),
		.address_latch_strobe_n_i(stb_n), .addr_i(addr), .async_page_select_i(page),
		.first_access_latency_i(lat), .wait_active_high_i(pol), .wait_early_release_i(early),
		.clock_edge_rising_i(rising), .burst_nowrap_i(nowrap), .burst_len_code_i(code),
		.word_addr_o(waddr), .data_valid_o(valid), .wait_o(wait_s), .wait_oe_o(wait_oe),
		.burst_active_o(active));

	flash_host_model flash_host_model_inst (.clock_i(clock_i), .rising_i(rising),
		.word_addr_i(waddr), .data_valid_i(valid), .wait_i(wait_s), .burst_clk_o(bclk),
		.chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .address_latch_strobe_n_o(stb_n),
		.addr_o(addr), .active_i(active));

	// verdict and end of run
	task automatic test_done();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	// hang guard
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic check(input logic [AW-1:0] got, input logic [AW-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask : check

	task automatic check_bit(input logic got, input logic exp);
		check({{(AW-1){1'b0}}, got}, {{(AW-1){1'b0}}, exp});
	endtask : check_bit

	// captured words against linear or wrapped order
	task automatic check_words(input logic [AW-1:0] s, input int len, input logic wrap);
		logic [AW-1:0] m;
		m = AW'(len - 1);
		check(AW'(flash_host_model_inst.words.size()), AW'(len));
		for (int i = 0; i < len; i++)
			check(flash_host_model_inst.words[i], wrap ? ((s & ~m) | ((s + AW'(i)) & m)) : s + AW'(i));
	endtask : check_words

	task automatic cfg(input logic [3:0] l, input logic e, input logic r, input logic w,
		input logic p, input logic [2:0] c);
		@(posedge clock_i);
		#1;
		{lat, early, rising, nowrap, pol, code} = {l, e, r, w, p, c};
	endtask : cfg

	task automatic t_latency();
		cfg(4'h3, 1'b0, 1'b1, 1'b0, 1'b1, bseq_pkg::BL_4);
		flash_host_model_inst.burst(26'h0000001, 8);
		check_bit(flash_host_model_inst.valids[2], 1'b0);
		check_bit(flash_host_model_inst.valids[3], 1'b1);
		check_bit(flash_host_model_inst.waits[2], 1'b1);
		check_bit(flash_host_model_inst.waits[3], 1'b0);
		check_words(26'h0000001, 4, 1'b1);
		check_bit(flash_host_model_inst.actives[0], 1'b1);
		check_bit(flash_host_model_inst.actives[7], 1'b0);
	endtask : t_latency

	task automatic t_lengths();
		int len;
		for (int c = 1; c <= 3; c++) begin
			for (int w = 0; w < 2; w++) begin
				len = 2 << c;
				cfg(4'h3, 1'b0, 1'b1, w[0], 1'b1, c[2:0]);
				flash_host_model_inst.burst(26'h0000004, len + 4);
				check_words(26'h0000004, len, !w[0]);
				check_bit(flash_host_model_inst.valids[len + 2], 1'b1);
				check_bit(flash_host_model_inst.valids[len + 3], 1'b0);
			end
		end
	endtask : t_lengths

	task automatic t_row_stall();
		cfg(4'h5, 1'b1, 1'b1, 1'b1, 1'b1, bseq_pkg::BL_16);
		flash_host_model_inst.burst(26'h000000f, 28);
		check_words(26'h000000f, 16, 1'b0);
		for (int i = 6; i < 10; i++) begin
			check_bit(flash_host_model_inst.valids[i], 1'b0);
			check_bit(flash_host_model_inst.waits[i], 1'b1);
		end
		check_bit(flash_host_model_inst.valids[24], 1'b1);
		check_bit(flash_host_model_inst.actives[8], 1'b1);
		check_bit(flash_host_model_inst.actives[28], 1'b0);
	endtask : t_row_stall

	task automatic t_edge_polarity();
		cfg(4'h4, 1'b1, 1'b0, 1'b0, 1'b0, bseq_pkg::BL_4);
		flash_host_model_inst.burst(26'h0000002, 9);
		check_bit(flash_host_model_inst.waits[2], 1'b0);
		check_bit(flash_host_model_inst.waits[3], 1'b1);
		check_bit(flash_host_model_inst.valids[3], 1'b0);
		check_words(26'h0000002, 4, 1'b1);
	endtask : t_edge_polarity

	task automatic t_continuous();
		cfg(4'h3, 1'b0, 1'b1, 1'b0, 1'b1, bseq_pkg::BL_CONT);
		flash_host_model_inst.burst(26'h3fffffd, 9);
		check_words(26'h3fffffd, 3, 1'b0);
	endtask : t_continuous

	task automatic t_bus_quiet();
		flash_host_model_inst.bus(1'b0, 1'b0);
		check_bit(wait_oe, 1'b1);
		flash_host_model_inst.bus(1'b0, 1'b1);
		check_bit(wait_oe, 1'b0);
		check_bit(wait_s, !pol);
		@(posedge clock_i);
		#1;
		page = 1'b1;
		flash_host_model_inst.burst(26'h0000000, 6);
		check_bit(flash_host_model_inst.waits[4], !pol);
		check_bit(flash_host_model_inst.actives[4], 1'b0);
		check(AW'(flash_host_model_inst.words.size()), '0);
	endtask : t_bus_quiet

	// main sequence
	initial begin
		repeat (6) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		t_latency();
		t_lengths();
		t_row_stall();
		t_edge_polarity();
		t_continuous();
		t_bus_quiet();
		test_done();
	end
endmodule : sync_burst_read_sequencer_bench
